// ==== hw/rcs_defines.svh ====
// Purpose: named constants for the remote command and fault status unit
// Assumes: included by its bare name from the design, the port checks and the bench
// Notes: definitions only
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// ascii codes met by the parser
`define RCS_CR 8'h0D
`define RCS_LF 8'h0A
`define RCS_SPACE 8'h20
`define RCS_QUOTE 8'h22
`define RCS_DOLLAR 8'h24
`define RCS_PLUS 8'h2B
`define RCS_MINUS 8'h2D
`define RCS_DOT 8'h2E
`define RCS_COLON 8'h3A
`define RCS_SEMI 8'h3B
`define RCS_DIG0 8'h30
`define RCS_DIG5 8'h35
`define RCS_DIG9 8'h39
`define RCS_UP_A 8'h41
`define RCS_UP_F 8'h46
`define RCS_UP_E 8'h45
`define RCS_UP_N 8'h4E
`define RCS_UP_O 8'h4F
`define RCS_LO_A 8'h61
`define RCS_LO_F 8'h66
`define RCS_LO_Z 8'h7A
`define RCS_CASE 8'h20
`define RCS_HEX_ALPHA 8'h37
`define RCS_NIB_TEN 4'hA

// implemented fault bits: 1..12 and 14..26
`define RCS_FAULT_MASK 32'h07FF_DFFE
`define RCS_ZERO8 8'h00
`define RCS_ZERO32 32'h0000_0000

`endif

// ==== hw/rcs_pkg.sv ====
// Purpose: types shared by the remote command and fault status unit
// Assumes: rcs_defines.svh holds the numbers
// Notes: one-hot state codes written out
package rcs_pkg;

  // receive parser states
  typedef enum logic [4:0] {
    RCS_ST_KEY = 5'h01,
    RCS_ST_PARAM = 5'h02,
    RCS_ST_SUM_HI = 5'h04,
    RCS_ST_SUM_LO = 5'h08,
    RCS_ST_SKIP = 5'h10
  } rcs_rx_e;

  // reply checksum appender states
  typedef enum logic [3:0] {
    RCS_TX_PASS = 4'h1,
    RCS_TX_DOL = 4'h2,
    RCS_TX_HI = 4'h4,
    RCS_TX_LO = 4'h8
  } rcs_tx_e;

  // parameter classes
  typedef enum logic [2:0] {
    RCS_P_NONE = 3'h0,
    RCS_P_INT = 3'h1,
    RCS_P_FIX = 3'h2,
    RCS_P_EXP = 3'h3,
    RCS_P_QSTR = 3'h4,
    RCS_P_USTR = 3'h5
  } rcs_pcls_e;

endpackage

// ==== hw/rcs_unit.sv ====
// Purpose: command text front end, reply checksum and fault register group
// Assumes: one byte per rx_valid cycle, synchronous inputs, 20 MHz clk
// Notes: keyword lookup and execution sit downstream of this block
`timescale 1ns/1ps
`include "rcs_defines.svh"

module rcs_unit
  import rcs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic kw_valid,
  output logic [7:0] kw_char,
  output logic kw_first,
  output logic kw_root,
  output logic kw_sep,
  output logic param_valid,
  output logic [7:0] param_char,
  output logic [7:0] param_fold,
  output logic cmd_end,
  output logic msg_end,
  output rcs_pcls_e param_class,
  output logic bool_val,
  output logic csum_seen,
  output logic csum_err,
  input wire logic rep_valid,
  input wire logic [7:0] rep_byte,
  input wire logic rep_last,
  output logic rep_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic [31:0] fault_in,
  input wire logic enable_wr,
  input wire logic [31:0] enable_wdata,
  input wire logic event_rd,
  output logic [31:0] fault_condition,
  output logic [31:0] fault_enable,
  output logic [31:0] fault_event_latch,
  output logic [31:0] event_rdata,
  output logic srq
);

  rcs_rx_e st; // parser state
  rcs_tx_e tst; // reply appender state
  rcs_pcls_e cls; // class of the parameter being read
  logic [7:0] rsum; // running sum of message text
  logic [7:0] tsum; // running sum of reply text
  logic [3:0] sum_hi; // first checksum digit
  logic cmd_start; // next keyword char opens a command
  logic at_root; // current command resolves from root
  logic in_quote; // inside a double quoted string
  logic p_first; // next param char is the first
  logic int_nz, frac_ge5, any_nz, seen_dot, frac_next; // numeric value tracking
  logic w_o, w_n; // first char O, second char N
  logic [1:0] w_len; // word length, saturating
  logic sum_pending; // message carried a checksum
  logic [31:0] next_event; // event latch next value

  // byte decode
  logic is_term, is_semi, is_colon, is_dollar, is_space, is_quote, is_digit;
  logic is_num, is_hex, ends_cmd, quote_mark;
  logic [3:0] nib;
  logic [7:0] up;
  logic [7:0] dig;

  // character classes and case fold of the incoming byte
  always_comb
  begin
    is_term = (rx_byte == `RCS_CR) || (rx_byte == `RCS_LF);
    is_semi = rx_byte == `RCS_SEMI;
    is_colon = rx_byte == `RCS_COLON;
    is_dollar = rx_byte == `RCS_DOLLAR;
    is_space = rx_byte == `RCS_SPACE;
    is_quote = rx_byte == `RCS_QUOTE;
    is_digit = (rx_byte >= `RCS_DIG0) && (rx_byte <= `RCS_DIG9);
    // lower case folded up so keyword and discrete compare case blind
    if ((rx_byte >= `RCS_LO_A) && (rx_byte <= `RCS_LO_Z))
      up = rx_byte - `RCS_CASE;
    else
      up = rx_byte;
    is_num = is_digit || (up == `RCS_UP_E) || (rx_byte == `RCS_DOT)
      || (rx_byte == `RCS_PLUS) || (rx_byte == `RCS_MINUS);
    dig = rx_byte - `RCS_DIG0;
    // hex digit value, either case accepted
    is_hex = 1'b1;
    if (is_digit)
      nib = dig[3:0];
    else if ((up >= `RCS_UP_A) && (up <= `RCS_UP_F))
      nib = 4'(up - `RCS_UP_A) + `RCS_NIB_TEN;
    else
    begin
      nib = 4'h0;
      is_hex = 1'b0;
    end
    quote_mark = (st == RCS_ST_PARAM) && is_quote && (cls == RCS_P_QSTR || p_first);
    // a semicolon or terminator inside quotes is string text
    ends_cmd = (is_term && !in_quote) || (is_semi && !in_quote
      && (st == RCS_ST_KEY || st == RCS_ST_PARAM));
  end

  // parser state; the dollar is only recognised outside quotes
  always_ff @(posedge clk)
  begin
    if (srst)
      st <= RCS_ST_KEY;
    else if (rx_valid)
    begin
      case (st)
        RCS_ST_KEY:
          if (is_dollar)
            st <= RCS_ST_SUM_HI;
          else if (is_space)
            st <= RCS_ST_PARAM;
        RCS_ST_PARAM:
          if (ends_cmd)
            st <= RCS_ST_KEY;
          else if (is_dollar && !in_quote)
            st <= RCS_ST_SUM_HI;
        RCS_ST_SUM_HI:
          if (is_term)
            st <= RCS_ST_KEY;
          else
            st <= RCS_ST_SUM_LO;
        RCS_ST_SUM_LO:
          if (is_term)
            st <= RCS_ST_KEY;
          else
            st <= RCS_ST_SKIP;
        RCS_ST_SKIP:
          if (is_term)
            st <= RCS_ST_KEY;
        default:
          st <= RCS_ST_KEY;
      endcase
    end
  end

  // message checksum: sum every byte before the dollar, compare two digits
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rsum <= `RCS_ZERO8;
      sum_hi <= 4'h0;
      csum_seen <= 1'b0;
      csum_err <= 1'b0;
      sum_pending <= 1'b0;
    end
    else if (rx_valid)
    begin
      if (is_term && !in_quote)
        rsum <= `RCS_ZERO8;
      else if ((st == RCS_ST_KEY || st == RCS_ST_PARAM) && !(is_dollar && !in_quote))
        rsum <= rsum + rx_byte;
      if (st == RCS_ST_SUM_HI)
      begin
        sum_hi <= nib;
        csum_seen <= 1'b1;
        sum_pending <= 1'b1;
        csum_err <= !is_hex || is_term;
      end
      else if (st == RCS_ST_SUM_LO)
        csum_err <= csum_err || !is_hex || is_term || ({sum_hi, nib} != rsum);
      else if (cmd_start && st == RCS_ST_KEY && !is_term)
      begin
        // new message text clears the previous verdict
        csum_seen <= 1'b0;
        csum_err <= 1'b0;
        sum_pending <= 1'b0;
      end
    end
  end

  // path flags: terminator or leading colon means root, semicolon keeps path
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_start <= 1'b1;
      at_root <= 1'b1;
    end
    else if (rx_valid)
    begin
      if (is_term && !in_quote)
      begin
        cmd_start <= 1'b1;
        at_root <= 1'b1;
      end
      else if (ends_cmd)
      begin
        cmd_start <= 1'b1;
        at_root <= 1'b0;
      end
      else if (st == RCS_ST_KEY && cmd_start && is_colon)
        at_root <= 1'b1;
      else if (st == RCS_ST_KEY && !is_space && !is_dollar)
        cmd_start <= 1'b0;
    end
  end

  // keyword stream, folded upper; inner colons mark a level step
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      kw_valid <= 1'b0;
      kw_char <= `RCS_ZERO8;
      kw_first <= 1'b0;
      kw_root <= 1'b0;
      kw_sep <= 1'b0;
    end
    else
    begin
      kw_valid <= rx_valid && st == RCS_ST_KEY && !is_colon && !is_semi
        && !is_term && !is_space && !is_dollar;
      kw_sep <= rx_valid && st == RCS_ST_KEY && is_colon && !cmd_start;
      if (rx_valid && st == RCS_ST_KEY && !is_colon)
      begin
        kw_char <= up;
        kw_first <= cmd_start;
        kw_root <= at_root;
      end
    end
  end

  // parameter stream: quotes stripped, raw and folded copies
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      param_valid <= 1'b0;
      param_char <= `RCS_ZERO8;
      param_fold <= `RCS_ZERO8;
      in_quote <= 1'b0;
    end
    else
    begin
      param_valid <= rx_valid && st == RCS_ST_PARAM && !quote_mark && !ends_cmd
        && !(is_dollar && !in_quote);
      if (rx_valid && st == RCS_ST_PARAM)
      begin
        param_char <= rx_byte;
        param_fold <= up;
        if (quote_mark)
          in_quote <= !in_quote;
      end
      if (rx_valid && is_term && !in_quote)
        in_quote <= 1'b0;
    end
  end

  // parameter class and boolean value tracking
  always_ff @(posedge clk)
  begin
    if (srst || (rx_valid && ends_cmd))
    begin
      cls <= RCS_P_NONE;
      p_first <= 1'b1;
      {int_nz, frac_ge5, any_nz, seen_dot, frac_next} <= 5'h00;
      {w_o, w_n} <= 2'h0;
      w_len <= 2'h0;
    end
    else if (rx_valid && st == RCS_ST_PARAM && !(is_dollar && !in_quote))
    begin
      p_first <= 1'b0;
      if (p_first && is_quote)
        cls <= RCS_P_QSTR;
      else if (p_first)
        cls <= !is_num ? RCS_P_USTR : (rx_byte == `RCS_DOT) ? RCS_P_FIX
          : RCS_P_INT;
      else if ((cls == RCS_P_INT || cls == RCS_P_FIX || cls == RCS_P_EXP) && !is_num)
        cls <= RCS_P_USTR;
      else if (cls == RCS_P_INT && rx_byte == `RCS_DOT)
        cls <= RCS_P_FIX;
      else if ((cls == RCS_P_INT || cls == RCS_P_FIX) && up == `RCS_UP_E)
        cls <= RCS_P_EXP;
      // value magnitude: any nonzero integer digit or first fraction digit of five up
      if (rx_byte == `RCS_DOT)
      begin
        seen_dot <= 1'b1;
        frac_next <= 1'b1;
      end
      else if (is_digit && cls != RCS_P_EXP && !(!p_first && up == `RCS_UP_E))
      begin
        frac_next <= 1'b0;
        if (!seen_dot && rx_byte != `RCS_DIG0)
          int_nz <= 1'b1;
        if (frac_next && rx_byte >= `RCS_DIG5)
          frac_ge5 <= 1'b1;
        if (rx_byte != `RCS_DIG0)
          any_nz <= 1'b1;
      end
      // word match for ON; any other word, OFF included, reads as false
      if (w_len == 2'h0)
        w_o <= up == `RCS_UP_O;
      if (w_len == 2'h1)
        w_n <= up == `RCS_UP_N;
      if (w_len != 2'h3)
        w_len <= w_len + 2'h1;
    end
  end

  // command results presented with the end of command pulse
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_end <= 1'b0;
      msg_end <= 1'b0;
      param_class <= RCS_P_NONE;
      bool_val <= 1'b0;
    end
    else
    begin
      cmd_end <= rx_valid && ends_cmd && !(is_term && cmd_start);
      msg_end <= rx_valid && is_term && !in_quote && !cmd_start;
      // the LF of a CR LF pair ends an empty command and must not wipe the result
      if (rx_valid && ends_cmd && !(is_term && cmd_start))
      begin
        param_class <= cls;
        case (cls)
          RCS_P_INT, RCS_P_FIX:
            bool_val <= int_nz || frac_ge5;
          RCS_P_EXP:
            bool_val <= any_nz;
          RCS_P_USTR:
            bool_val <= w_o && w_n && w_len == 2'h2;
          default:
            bool_val <= 1'b0;
        endcase
      end
    end
  end

  // reply path: pass bytes, then after a checksummed message append dollar and two hex digits
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tst <= RCS_TX_PASS;
      tsum <= `RCS_ZERO8;
      rep_ready <= 1'b1;
      tx_valid <= 1'b0;
      tx_byte <= `RCS_ZERO8;
    end
    else
    begin
      tx_valid <= 1'b0;
      case (tst)
        RCS_TX_PASS:
          if (rep_valid && rep_ready)
          begin
            tx_valid <= 1'b1;
            tx_byte <= rep_byte;
            tsum <= rep_last ? (sum_pending ? tsum + rep_byte : `RCS_ZERO8)
              : tsum + rep_byte;
            if (rep_last && sum_pending)
            begin
              rep_ready <= 1'b0; // stall the source while digits go out
              tst <= RCS_TX_DOL;
            end
          end
        RCS_TX_DOL:
        begin
          tx_valid <= 1'b1;
          tx_byte <= `RCS_DOLLAR;
          tst <= RCS_TX_HI;
        end
        RCS_TX_HI:
        begin
          tx_valid <= 1'b1;
          tx_byte <= to_hex(tsum[7:4]);
          tst <= RCS_TX_LO;
        end
        RCS_TX_LO:
        begin
          tx_valid <= 1'b1;
          tx_byte <= to_hex(tsum[3:0]);
          tsum <= `RCS_ZERO8;
          rep_ready <= 1'b1;
          tst <= RCS_TX_PASS;
        end
        default:
          tst <= RCS_TX_PASS;
      endcase
    end
  end

  // nibble to upper case ascii hex
  function automatic logic [7:0] to_hex(input logic [3:0] n);
    if (n < `RCS_NIB_TEN)
      to_hex = `RCS_DIG0 + {4'h0, n};
    else
      to_hex = `RCS_HEX_ALPHA + {4'h0, n};
  endfunction

  // event latch: set beats the read clear so no event is lost
  always_comb
  begin
    next_event = (fault_event_latch & ~{32{event_rd}})
      | (fault_condition & fault_enable);
  end

  // fault condition, enable, event and read data
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fault_condition <= `RCS_ZERO32;
      fault_enable <= `RCS_ZERO32;
      fault_event_latch <= `RCS_ZERO32;
      event_rdata <= `RCS_ZERO32;
      srq <= 1'b0;
    end
    else
    begin
      fault_condition <= fault_in & `RCS_FAULT_MASK;
      if (enable_wr)
        fault_enable <= enable_wdata & `RCS_FAULT_MASK;
      fault_event_latch <= next_event;
      if (event_rd)
        event_rdata <= fault_event_latch;
      srq <= |next_event;
    end
  end

endmodule

// ==== dv/rcs_unit_properties.sv ====
// Purpose: port checks for rcs_unit
// Assumes: one clock, srst synchronous high
// Notes: bound to the design below
`timescale 1ns/1ps
`include "rcs_defines.svh"

module rcs_unit_props
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] fault_in,
  input wire logic enable_wr,
  input wire logic [31:0] enable_wdata,
  input wire logic event_rd,
  input wire logic [31:0] fault_condition,
  input wire logic [31:0] fault_enable,
  input wire logic [31:0] fault_event_latch,
  input wire logic [31:0] event_rdata,
  input wire logic srq,
  input wire logic rep_valid,
  input wire logic [7:0] rep_byte,
  input wire logic rep_last,
  input wire logic rep_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic csum_seen
);
  // single domain, so clock and disable are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  cond_mirror_a: assert property (
    !$past(srst) |-> fault_condition == ($past(fault_in) & `RCS_FAULT_MASK))
    else $error("condition lost fault input");
  unused_zero_a: assert property (
    ((fault_condition | fault_event_latch | fault_enable) & ~`RCS_FAULT_MASK) == 0)
    else $error("unused bit set");
  latch_gate_a: assert property (
    (fault_event_latch & ~$past(fault_event_latch) & ~$past(fault_enable)) == 0)
    else $error("event latched while disabled");
  event_sticky_a: assert property (
    !$past(srst) && !$past(event_rd) |-> ($past(fault_event_latch) & ~fault_event_latch) == 0)
    else $error("event dropped without read");
  read_value_a: assert property (
    event_rd |=> event_rdata == $past(fault_event_latch))
    else $error("read value wrong");
  enable_write_a: assert property (
    enable_wr |=> fault_enable == ($past(enable_wdata) & `RCS_FAULT_MASK))
    else $error("enable write wrong");
  srq_level_a: assert property (
    srq == (fault_event_latch != 0))
    else $error("srq wrong");
  reply_pass_a: assert property (
    rep_valid && rep_ready |=> tx_valid && tx_byte == $past(rep_byte))
    else $error("reply byte lost");
  sum_marker_a: assert property (
    csum_seen && rep_valid && rep_ready && rep_last |=> ##1 tx_valid && tx_byte == 8'h24)
    else $error("no dollar after reply");
  reply_stall_a: assert property (
    csum_seen && rep_valid && rep_ready && rep_last |=> !rep_ready [*3] ##1 rep_ready)
    else $error("reply source not held for digits");
endmodule

bind rcs_unit rcs_unit_props u_props (
  .clk(clk), .srst(srst), .fault_in(fault_in), .enable_wr(enable_wr),
  .enable_wdata(enable_wdata), .event_rd(event_rd), .fault_condition(fault_condition),
  .fault_enable(fault_enable), .fault_event_latch(fault_event_latch),
  .event_rdata(event_rdata), .srq(srq), .rep_valid(rep_valid), .rep_byte(rep_byte),
  .rep_last(rep_last), .rep_ready(rep_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .csum_seen(csum_seen)
);

// ==== dv/rcs_host_model.sv ====
// Purpose: controlling computer sending text and a reply source
// Assumes: called at a rising edge
// Notes: released lines show the inverse of their last byte
`timescale 1ns/1ps

module rcs_host_model
(
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rep_valid,
  output logic [7:0] rep_byte,
  output logic rep_last,
  input wire logic rep_ready
);
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'hA5;
    rep_valid = 1'b0;
    rep_byte = 8'h5A;
    rep_last = 1'b0;
  end

  // mode 0 plain, 1 good sum, 2 corrupted sum
  task automatic send(input string s, input int mode, input string term);
    logic [7:0] sum;
    string t;
    sum = 8'h00;
    for (int i = 0; i < s.len(); i++)
      sum = sum + 8'(s[i]);
    if (mode == 2)
      sum = sum + 8'h01;
    // dollar right after text, no terminator between
    t = (mode != 0) ? $sformatf("%s$%02X", s, sum) : s;
    t = {t, term};
    for (int i = 0; i < t.len(); i++)
    begin
      rx_valid <= 1'b1;
      rx_byte <= t[i];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_byte <= ~t[t.len()-1];
  endtask

  // holds each byte until rep_ready is seen at an edge
  task automatic reply(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      rep_valid <= 1'b1;
      rep_byte <= s[i];
      rep_last <= (i == s.len() - 1);
      @(posedge clk);
      while (!rep_ready)
        @(posedge clk);
    end
    rep_valid <= 1'b0;
    rep_last <= 1'b0;
    rep_byte <= ~s[s.len()-1];
  endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for rcs_unit
// Assumes: 20 MHz clk, reset held 10 cycles
// Notes: host model drives the receive and reply sides
`timescale 1ns/1ps
`include "rcs_defines.svh"

module tb
  import rcs_pkg::*;
();
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rx_valid, rep_valid, rep_last, rep_ready, tx_valid;
  logic [7:0] rx_byte, kw_char, param_char, param_fold, rep_byte, tx_byte;
  logic kw_valid, kw_first, kw_root, kw_sep, param_valid, cmd_end, msg_end;
  logic bool_val, csum_seen, csum_err, srq;
  logic enable_wr = 1'b0;
  logic event_rd = 1'b0;
  logic [31:0] fault_in = 32'h0000_0000;
  logic [31:0] enable_wdata = 32'h0000_0000;
  logic [31:0] fault_condition, fault_enable, fault_event_latch, event_rdata;
  rcs_pcls_e param_class;
  int error_cnt = 0;
  int total_checks = 0;
  int n_msg, n_sep;
  string kw_s, pr_s, pf_s, tx_s;
  logic [7:0] rts, bls;
  logic [23:0] cls;
  string nv[9] = '{"0240", "255", ".0253", "0.5", "-0.4", "03.5E+1", "0.0E+0", "1",
    "\"Ab;c\""};
  logic [2:0] nc[9] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h1, 3'h4};
  logic [8:0] nb = 9'b110101010;

  // 50 ns period
  always #25 clk = ~clk;

  rcs_unit DUT (
    .clk(clk), .srst(srst), .rx_valid(rx_valid), .rx_byte(rx_byte), .kw_valid(kw_valid),
    .kw_char(kw_char), .kw_first(kw_first), .kw_root(kw_root), .kw_sep(kw_sep),
    .param_valid(param_valid), .param_char(param_char), .param_fold(param_fold),
    .cmd_end(cmd_end), .msg_end(msg_end), .param_class(param_class), .bool_val(bool_val),
    .csum_seen(csum_seen), .csum_err(csum_err), .rep_valid(rep_valid),
    .rep_byte(rep_byte), .rep_last(rep_last), .rep_ready(rep_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .fault_in(fault_in), .enable_wr(enable_wr),
    .enable_wdata(enable_wdata), .event_rd(event_rd), .fault_condition(fault_condition),
    .fault_enable(fault_enable), .fault_event_latch(fault_event_latch),
    .event_rdata(event_rdata), .srq(srq)
  );

  rcs_host_model host (
    .clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rep_valid(rep_valid),
    .rep_byte(rep_byte), .rep_last(rep_last), .rep_ready(rep_ready)
  );

  // gathers the parser and reply outputs into strings and shift words
  always @(posedge clk)
  begin
    if (kw_valid && kw_first)
      rts = {rts[6:0], kw_root};
    if (kw_valid)
      kw_s = $sformatf("%s%c", kw_s, kw_char);
    if (param_valid)
    begin
      pr_s = $sformatf("%s%c", pr_s, param_char);
      pf_s = $sformatf("%s%c", pf_s, param_fold);
    end
    if (tx_valid)
      tx_s = $sformatf("%s%c", tx_s, tx_byte);
    if (kw_sep)
      n_sep++;
    if (msg_end)
      n_msg++;
    if (cmd_end)
    begin
      cls = {cls[20:0], param_class};
      bls = {bls[6:0], bool_val};
    end
  end

  task automatic clr;
    kw_s = "";
    pr_s = "";
    pf_s = "";
    tx_s = "";
    rts = 8'h00;
    bls = 8'h00;
    cls = 24'h000000;
    n_msg = 0;
    n_sep = 0;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog well past the expected run
  initial
  begin
    #(20000 * 50);
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // concatenated paths, case folding, words
    clr();
    host.send("outp:ena ON;LATC OFF;:curr 30", 0, "\n");
    repeat (3) @(posedge clk);
    chk("kw", 32'(kw_s == "OUTPENALATCCURR"), 1);
    chk("root", 32'(rts), 32'h5);
    chk("sep", 32'(n_sep), 1);
    chk("par", 32'(pr_s == "ONOFF30"), 1);
    chk("cls", 32'(cls[8:0]), {23'h0, 3'h5, 3'h5, 3'h1});
    chk("bool", 32'(bls[2:0]), 32'h5);
    chk("msgs", 32'(n_msg), 1);
    $display("test paths done");
    // numeric and quoted string classes, boolean values; CR LF endings
    clr();
    for (int i = 0; i < 9; i++)
    begin
      host.send({"VOLT ", nv[i]}, 0, "\r\n");
      repeat (3) @(posedge clk);
      chk(nv[i], 32'(param_class), 32'(nc[i]));
      if (i < 8)
        chk(nv[i], 32'(bool_val), 32'(nb[8-i]));
    end
    chk("msgs", 32'(n_msg), 9);
    chk("qstr", 32'(pr_s.substr(pr_s.len() - 4, pr_s.len() - 1) == "Ab;c"), 1);
    chk("qfold", 32'(pf_s.substr(pf_s.len() - 4, pf_s.len() - 1) == "AB;C"), 1);
    $display("test formats done");
    // checksum in, checksum on reply
    clr();
    host.send("OUT?", 1, "\n");
    repeat (3) @(posedge clk);
    chk("seen", 32'(csum_seen), 1);
    chk("err", 32'(csum_err), 0);
    host.reply("A");
    repeat (6) @(posedge clk);
    chk("tx", 32'(tx_s == "A$41"), 1);
    host.send("OUT?", 2, "\n");
    repeat (3) @(posedge clk);
    chk("bad", 32'(csum_err), 1);
    clr();
    host.send("OUT?", 0, "\n");
    repeat (3) @(posedge clk);
    chk("none", 32'(csum_seen), 0);
    host.reply("A");
    repeat (6) @(posedge clk);
    chk("tx2", 32'(tx_s == "A"), 1);
    $display("test checksum done");
    // fault group: mirror, latch, sticky, read clear, gating
    enable_wr <= 1'b1;
    enable_wdata <= 32'hFFFF_FFFF;
    @(posedge clk);
    enable_wr <= 1'b0;
    fault_in <= 32'hFFFF_FFFF;
    repeat (4) @(posedge clk);
    chk("en", fault_enable, `RCS_FAULT_MASK);
    chk("cond", fault_condition, `RCS_FAULT_MASK);
    chk("evt", fault_event_latch, `RCS_FAULT_MASK);
    chk("srq", 32'(srq), 1);
    fault_in <= 32'h0000_0000;
    repeat (3) @(posedge clk);
    chk("cond0", fault_condition, 0);
    chk("stick", fault_event_latch, `RCS_FAULT_MASK);
    event_rd <= 1'b1;
    @(posedge clk);
    event_rd <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rd", event_rdata, `RCS_FAULT_MASK);
    chk("clr", fault_event_latch, 0);
    chk("srq0", 32'(srq), 0);
    enable_wr <= 1'b1;
    enable_wdata <= 32'h0000_0010;
    @(posedge clk);
    enable_wr <= 1'b0;
    fault_in <= 32'h0000_2091;
    repeat (4) @(posedge clk);
    chk("gate", fault_event_latch, 32'h0000_0010);
    $display("test faults done");
    // reset in mid-run: latched event and enable gone, live faults come back
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("rst_en", fault_enable, 0);
    chk("rst_evt", fault_event_latch, 0);
    chk("rst_rdy", 32'(rep_ready), 1);
    repeat (2) @(posedge clk);
    chk("rst_cond", fault_condition, 32'h0000_0090);
    chk("rst_gate", fault_event_latch, 0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
